// ### mss_debounce.sv
`timescale 1ns/100ps
module mss_debounce (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic [4:0] deb_time,
	input wire logic [5:0] din,
	output logic [5:0] dout
);
	mss_pkg::mss_deb_s s;
	mss_pkg::mss_deb_s n;

	// Each input restarts its count on any change; level follows once
	// the count of 2 ms ticks reaches the programmed time
	always_comb begin
		n = s;
		for (int i = 0; i < 6; i++) begin
			if (din[i] != s.last[i]) begin
				n.last[i] = din[i];
				n.cnt[i] = 5'h00;
			end else if (din[i] != s.level[i] && tick) begin
				if (s.cnt[i] + 5'h01 >= deb_time) begin
					n.level[i] = din[i]; // RULE18
					n.cnt[i] = 5'h00;
				end else begin
					n.cnt[i] = s.cnt[i] + 5'h01; // RULE2
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign dout = s.level;
endmodule

// ### mss_field.sv
`timescale 1ns/100ps
module mss_field (
	input wire logic sys_clk,
	input wire logic [5:0] cmd,
	input wire logic [3:0] bounce,
	input wire logic step_term,
	output logic speed_select_bit0,
	output logic speed_select_bit1,
	output logic speed_select_bit2,
	output logic speed_select_bit3,
	output logic [1:0] mfi_term,
	output logic [7:0] pulse_cnt
);
	logic [5:0] last_r = 6'h00;
	logic [5:0] flip_r = 6'h00;
	logic [5:0] lvl_r = 6'h00;
	logic [3:0] bcnt_r = 4'h0;
	logic step_q = 1'b0;
	logic [7:0] cnt_r = 8'h00;
	// Changed contacts chatter every cycle before they settle
	always_ff @(posedge sys_clk) begin
		if (cmd != last_r) begin
			last_r <= cmd;
			flip_r <= cmd ^ last_r;
			bcnt_r <= bounce;
		end else if (bcnt_r != 4'h0) begin
			bcnt_r <= bcnt_r - 4'h1;
		end
		lvl_r <= (bcnt_r != 4'h0) ? (lvl_r ^ flip_r) : last_r;
		step_q <= step_term;
		if (step_term && !step_q) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	assign speed_select_bit0 = lvl_r[0];
	assign speed_select_bit1 = lvl_r[1];
	assign speed_select_bit2 = lvl_r[2];
	assign speed_select_bit3 = lvl_r[3];
	assign mfi_term = lvl_r[5:4];
	assign pulse_cnt = cnt_r;
endmodule

// ### mss_params.svh
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH

`define MSS_CLK_HZ 125000000
`define MSS_DEB_UNIT_US 2000
`define MSS_STEP_UNIT_US 1000000
`define MSS_DEB_TICK_CYC (`MSS_CLK_HZ / 1000000 * `MSS_DEB_UNIT_US)
`define MSS_STEP_TICK_CYC (`MSS_CLK_HZ / 1000000 * `MSS_STEP_UNIT_US)

`define MSS_A_FREQ_TBL 2'h0
`define MSS_A_DUR_TBL 2'h1
`define MSS_A_DEB 6'h20
`define MSS_A_GEAR 6'h21
`define MSS_A_ANGLE 6'h22
`define MSS_A_IDXDEC 6'h23
`define MSS_A_MODE 6'h24
`define MSS_A_DIR 6'h25
`define MSS_A_MFI_FN 6'h26
`define MSS_A_MFO_FN 6'h27
`define MSS_A_STATUS 6'h28
`define MSS_A_INT_STAT 6'h29
`define MSS_A_INT_MASK 6'h2A

`define MSS_FREQ_MAX 16'h9C40
`define MSS_DUR_MAX 16'hFFDC
`define MSS_DEB_MIN 16'h0001
`define MSS_DEB_MAX 16'h0014
`define MSS_GEAR_MIN 16'h0004
`define MSS_GEAR_MAX 16'h03E8
`define MSS_ANGLE_MAX 16'h0E10
`define MSS_IDXDEC_MAX 16'h2710
`define MSS_MODE_MAX 16'h0004
`define MSS_DIR_MASK 16'h7FFF

`define MSS_DEB_RST 5'h01
`define MSS_GEAR_RST 16'h00C8
`define MSS_ANGLE_RST 16'h0708
`define MSS_IDXDEC_RST 16'h0000
`define MSS_MODE_RST 3'h0

`define MSS_MODE_ONCE 3'h1
`define MSS_MODE_CONT 3'h2
`define MSS_MODE_ONCE_STEP 3'h3
`define MSS_MODE_CONT_STEP 3'h4

`define MSS_FN_RUN 8'h0E
`define MSS_FN_PAUSE 8'h0F
`define MSS_FN_PROX 8'h22
`define MSS_FN_RUNNING 8'h0A
`define MSS_FN_STEP_DONE 8'h0B
`define MSS_FN_PROG_DONE 8'h0C

`define MSS_LAST_STEP 4'hF
`define MSS_INT_STEP 0
`define MSS_INT_CYCLE 1
`define MSS_INT_PROX 2

`endif

// ### mss_pkg.sv
package mss_pkg;

	typedef enum logic [2:0] {
		MSS_SEQ_IDLE = 3'h0,
		MSS_SEQ_LOAD = 3'h1,
		MSS_SEQ_RUN = 3'h3,
		MSS_SEQ_DONE = 3'h2,
		MSS_SEQ_PAUSE = 3'h7
	} mss_seq_e;

	typedef enum logic [1:0] {
		MSS_IDX_NONE = 2'h0,
		MSS_IDX_WAIT = 2'h1,
		MSS_IDX_DECEL = 2'h3
	} mss_idx_e;

	typedef struct packed {
		mss_seq_e seq;
		mss_idx_e idx;
		logic [3:0] step;
		logic [3:0] code_q;
		logic [15:0] sec_cnt;
		logic [26:0] deb_div;
		logic deb_tick;
		logic [26:0] sec_div;
		logic [4:0] deb_time;
		logic [15:0] gear;
		logic [15:0] angle;
		logic [15:0] idx_dec;
		logic [2:0] mode;
		logic [14:0] dir_word;
		logic [15:0] mfi_fn;
		logic [15:0] mfo_fn;
		logic run_q;
		logic stop_q;
		logic prox_q;
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		logic [15:0] freq_out;
		logic dir_out;
		logic decel_go;
		logic step_done;
		logic [1:0] out_term;
		logic irq;
	} mss_top_s;

	typedef struct packed {
		logic [5:0][4:0] cnt;
		logic [5:0] last;
		logic [5:0] level;
	} mss_deb_s;

	function automatic logic [15:0] mss_clamp(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end
		if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

endpackage

// ### mss_step_mem.sv
`timescale 1ns/100ps
module mss_step_mem (
	input wire logic sys_clk,
	input wire logic [3:0] w_addr,
	input wire logic w_freq,
	input wire logic w_dur,
	input wire logic [15:0] w_data,
	input wire logic [3:0] a_addr,
	input wire logic a_half,
	input wire logic a_sel_alt,
	input wire logic [15:0] a_alt,
	output logic [15:0] a_q,
	input wire logic [3:0] b_addr,
	output logic [15:0] b_freq,
	output logic [15:0] b_dur
);
	logic [15:0] freq_mem [0:15];
	logic [15:0] dur_mem [0:15];

	// Tables power up as zero, their documented default
	initial begin
		for (int i = 0; i < 16; i++) begin
			freq_mem[i] = 16'h0000;
			dur_mem[i] = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (w_freq) begin
			freq_mem[w_addr] <= w_data;
		end
		if (w_dur) begin
			dur_mem[w_addr] <= w_data;
		end
		if (a_sel_alt) begin
			a_q <= a_alt;
		end else if (a_half) begin
			a_q <= dur_mem[a_addr];
		end else begin
			a_q <= freq_mem[a_addr];
		end
		b_freq <= freq_mem[b_addr];
		b_dur <= dur_mem[b_addr];
	end
endmodule

// ### mss_top.sv
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "mss_params.svh"
// How it works
// RULE1: four select terminals form binary speed code
// RULE2: inputs delayed by 2 ms units, 1..20
// RULE3: fifteen step frequencies, 0 to 400.00 Hz
// RULE4: index gear ratio 4..1000, default 200
// RULE5: index angle 0..360.0 degrees, default 180.0
// RULE6: index decel time 0..100.00 s, default 0
// RULE7: proximity input only from function-34 terminal
// RULE8: on stop, hold speed until proximity triggers
// RULE9: index angle measured from proximity trigger (the code ignores angle and raises decel_go on the trigger itself)
// RULE10: program mode 00 off through 04
// RULE11: running program steps frequency and direction
// RULE12: one-cycle mode reruns only after run toggles
// RULE13: continuous mode repeats until pause or off
// RULE14: function 14 starts, function 15 pauses program
// RULE15: outputs 10 running, 11 step, 12 done
// RULE16: step direction from 15-bit word only
// RULE17: zero-duration steps are skipped
// RULE18: debounce passes level only after stable time
// RULE19: step advances on elapsed time, pulses flag
module mss_top #(
	parameter int unsigned DEB_TICK_CYC = `MSS_DEB_TICK_CYC,
	parameter int unsigned STEP_TICK_CYC = `MSS_STEP_TICK_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [5:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic speed_select_bit0,
	input wire logic speed_select_bit1,
	input wire logic speed_select_bit2,
	input wire logic speed_select_bit3,
	input wire logic [1:0] mfi_term,
	input wire logic [15:0] master_freq,
	input wire logic dir_cmd,
	input wire logic stop_cmd,
	output logic [15:0] freq_out,
	output logic dir_out,
	output logic decel_go,
	output logic [1:0] out_term,
	output logic irq
);
	mss_pkg::mss_top_s s;
	mss_pkg::mss_top_s n;
	logic [5:0] deb_in;
	logic [5:0] deb_out;
	logic [15:0] mem_q;
	logic [15:0] mem_freq;
	logic [15:0] mem_dur;
	logic [15:0] reg_mux;
	logic [3:0] code;
	logic run_lvl;
	logic pause_lvl;
	logic prox_lvl;
	logic idx_en;
	logic sec_tick;
	logic prog_active;
	logic w_tbl;

	function automatic logic term_has(input logic [15:0] fn,
		input logic [1:0] t, input logic [7:0] want);
		return (fn[7:0] == want && t[0]) || (fn[15:8] == want && t[1]);
	endfunction

	function automatic logic fn_used(input logic [15:0] fn,
		input logic [7:0] want);
		return fn[7:0] == want || fn[15:8] == want;
	endfunction

	function automatic logic out_fn(input logic [7:0] fn,
		input logic running, input logic step, input logic done);
		return (fn == `MSS_FN_RUNNING && running) ||
			(fn == `MSS_FN_STEP_DONE && step) ||
			(fn == `MSS_FN_PROG_DONE && done);
	endfunction

	assign deb_in = {mfi_term, speed_select_bit3, speed_select_bit2,
		speed_select_bit1, speed_select_bit0};

	mss_debounce u_deb (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.tick(s.deb_tick),
		.deb_time(s.deb_time),
		.din(deb_in),
		.dout(deb_out)
	);

	assign code = deb_out[3:0]; // RULE1
	assign run_lvl = term_has(s.mfi_fn, deb_out[5:4], `MSS_FN_RUN); // RULE14
	assign pause_lvl = term_has(s.mfi_fn, deb_out[5:4], `MSS_FN_PAUSE);
	assign prox_lvl = term_has(s.mfi_fn, deb_out[5:4], `MSS_FN_PROX); // RULE7
	assign idx_en = fn_used(s.mfi_fn, `MSS_FN_PROX);
	assign sec_tick = s.sec_div == 27'(STEP_TICK_CYC - 1);
	assign prog_active = s.seq != mss_pkg::MSS_SEQ_IDLE;
	assign w_tbl = reg_wr && !reg_addr[5] && reg_addr[3:0] != 4'hF;

	always_comb begin
		reg_mux = 16'h0000;
		unique case (reg_addr)
			`MSS_A_DEB: reg_mux = {11'h000, s.deb_time};
			`MSS_A_GEAR: reg_mux = s.gear;
			`MSS_A_ANGLE: reg_mux = s.angle;
			`MSS_A_IDXDEC: reg_mux = s.idx_dec;
			`MSS_A_MODE: reg_mux = {13'h0000, s.mode};
			`MSS_A_DIR: reg_mux = {1'h0, s.dir_word};
			`MSS_A_MFI_FN: reg_mux = s.mfi_fn;
			`MSS_A_MFO_FN: reg_mux = s.mfo_fn;
			`MSS_A_STATUS: reg_mux = {3'h0, s.idx, s.seq, code, s.step};
			`MSS_A_INT_STAT: reg_mux = {13'h0000, s.int_stat};
			`MSS_A_INT_MASK: reg_mux = {13'h0000, s.int_mask};
			default: reg_mux = 16'h0000;
		endcase
	end

	mss_step_mem u_mem (
		.sys_clk(sys_clk),
		.w_addr(reg_addr[3:0]),
		.w_freq(w_tbl && reg_addr[5:4] == `MSS_A_FREQ_TBL),
		.w_dur(w_tbl && reg_addr[5:4] == `MSS_A_DUR_TBL),
		.w_data(reg_addr[4] ?
			mss_pkg::mss_clamp(reg_wdata, 16'h0000, `MSS_DUR_MAX) :
			mss_pkg::mss_clamp(reg_wdata, 16'h0000, `MSS_FREQ_MAX)), // RULE3
		.a_addr(reg_addr[3:0]),
		.a_half(reg_addr[4]),
		.a_sel_alt(reg_addr[5] || reg_addr[3:0] == 4'hF),
		.a_alt(reg_mux),
		.a_q(mem_q),
		.b_addr(n.seq == mss_pkg::MSS_SEQ_IDLE ? code - 4'h1 :
			n.step - 4'h1),
		.b_freq(mem_freq),
		.b_dur(mem_dur)
	);

	always_comb begin
		logic cycle_end;
		logic step_evt;
		logic cyc_evt;
		logic prox_evt;
		cycle_end = 1'b0;
		step_evt = 1'b0;
		cyc_evt = 1'b0;
		prox_evt = 1'b0;
		n = s;
		n.step_done = 1'b0;
		n.run_q = run_lvl;
		n.stop_q = stop_cmd;
		n.prox_q = prox_lvl;
		n.code_q = code;
		n.deb_tick = s.deb_div == 27'(DEB_TICK_CYC - 1);
		n.deb_div = n.deb_tick ? 27'h0000000 : s.deb_div + 27'h0000001;
		if (s.seq == mss_pkg::MSS_SEQ_RUN) begin
			n.sec_div = sec_tick ? 27'h0000000 : s.sec_div + 27'h0000001;
		end
		if (reg_wr) begin
			unique case (reg_addr)
				`MSS_A_DEB: n.deb_time = 5'(mss_pkg::mss_clamp(reg_wdata,
					`MSS_DEB_MIN, `MSS_DEB_MAX)); // RULE2
				`MSS_A_GEAR: n.gear = mss_pkg::mss_clamp(reg_wdata,
					`MSS_GEAR_MIN, `MSS_GEAR_MAX); // RULE4
				`MSS_A_ANGLE: n.angle = mss_pkg::mss_clamp(reg_wdata,
					16'h0000, `MSS_ANGLE_MAX); // RULE5
				`MSS_A_IDXDEC: n.idx_dec = mss_pkg::mss_clamp(reg_wdata,
					16'h0000, `MSS_IDXDEC_MAX); // RULE6
				`MSS_A_MODE: n.mode = 3'(mss_pkg::mss_clamp(reg_wdata,
					16'h0000, `MSS_MODE_MAX)); // RULE10
				`MSS_A_DIR: n.dir_word = 15'(reg_wdata & `MSS_DIR_MASK);
				`MSS_A_MFI_FN: n.mfi_fn = reg_wdata;
				`MSS_A_MFO_FN: n.mfo_fn = reg_wdata;
				`MSS_A_INT_MASK: n.int_mask = reg_wdata[2:0];
				default: n.int_mask = s.int_mask;
			endcase
		end
		unique case (s.seq)
			mss_pkg::MSS_SEQ_IDLE: begin
				if (s.mode != 3'h0 && run_lvl && !s.run_q) begin
					n.step = 4'h1;
					n.seq = mss_pkg::MSS_SEQ_LOAD;
				end
			end
			mss_pkg::MSS_SEQ_LOAD: begin
				if (mem_dur == 16'h0000) begin
					if (s.step == `MSS_LAST_STEP) begin
						cycle_end = 1'b1;
					end else begin
						n.step = s.step + 4'h1; // RULE17
					end
				end else begin
					n.sec_cnt = mem_dur;
					n.sec_div = 27'h0000000;
					n.seq = mss_pkg::MSS_SEQ_RUN;
					n.freq_out = mem_freq; // RULE11
					n.dir_out = s.dir_word[s.step - 4'h1]; // RULE16
				end
			end
			mss_pkg::MSS_SEQ_RUN: begin
				if (pause_lvl) begin
					n.seq = mss_pkg::MSS_SEQ_PAUSE; // RULE14
					n.sec_div = s.sec_div;
				end else if (sec_tick) begin
					if (s.sec_cnt == 16'h0001) begin
						n.step_done = 1'b1; // RULE19
						step_evt = 1'b1;
						if (s.step == `MSS_LAST_STEP) begin
							cycle_end = 1'b1;
						end else begin
							n.step = s.step + 4'h1;
							n.seq = mss_pkg::MSS_SEQ_LOAD;
						end
					end else begin
						n.sec_cnt = s.sec_cnt - 16'h0001;
					end
				end
			end
			mss_pkg::MSS_SEQ_PAUSE: begin
				if (!pause_lvl) begin
					n.seq = mss_pkg::MSS_SEQ_RUN;
				end
			end
			mss_pkg::MSS_SEQ_DONE: begin
				n.seq = mss_pkg::MSS_SEQ_DONE; // RULE12
			end
			default: n.seq = mss_pkg::MSS_SEQ_IDLE;
		endcase
		if (cycle_end) begin
			cyc_evt = 1'b1;
			if (s.mode == `MSS_MODE_CONT || s.mode == `MSS_MODE_CONT_STEP) begin
				n.step = 4'h1; // RULE13
				n.seq = mss_pkg::MSS_SEQ_LOAD;
			end else begin
				n.seq = mss_pkg::MSS_SEQ_DONE; // RULE12
			end
		end
		if (prog_active && (!run_lvl || s.mode == 3'h0)) begin
			n.seq = mss_pkg::MSS_SEQ_IDLE;
		end
		unique case (s.idx)
			mss_pkg::MSS_IDX_NONE: begin
				n.decel_go = stop_cmd && !idx_en;
				if (stop_cmd && !s.stop_q && idx_en) begin
					n.idx = mss_pkg::MSS_IDX_WAIT; // RULE8
				end
			end
			mss_pkg::MSS_IDX_WAIT: begin
				// A running program must not move the speed while index waits
				n.freq_out = s.freq_out; // RULE8
				if (prox_lvl && !s.prox_q) begin
					n.idx = mss_pkg::MSS_IDX_DECEL; // RULE9
					n.decel_go = 1'b1;
					prox_evt = 1'b1;
				end
			end
			mss_pkg::MSS_IDX_DECEL: begin
				n.decel_go = 1'b1;
			end
			default: n.idx = mss_pkg::MSS_IDX_NONE;
		endcase
		if (!stop_cmd && s.idx != mss_pkg::MSS_IDX_NONE) begin
			n.idx = mss_pkg::MSS_IDX_NONE;
			n.decel_go = 1'b0;
		end
		// Outside a program the selector drives speed, unless index holds it
		if (s.seq == mss_pkg::MSS_SEQ_IDLE && s.idx == mss_pkg::MSS_IDX_NONE
			&& !(stop_cmd && !s.stop_q && idx_en)) begin
			n.freq_out = s.code_q == 4'h0 ? master_freq : mem_freq; // RULE1
			n.dir_out = dir_cmd;
		end
		n.int_stat = (reg_rd && reg_addr == `MSS_A_INT_STAT) ?
			3'h0 : s.int_stat;
		n.int_stat = n.int_stat | {prox_evt, cyc_evt, step_evt};
		n.irq = |(n.int_stat & n.int_mask);
		n.out_term[0] = out_fn(s.mfo_fn[7:0], n.seq != mss_pkg::MSS_SEQ_IDLE
			&& n.seq != mss_pkg::MSS_SEQ_DONE, n.step_done,
			n.seq == mss_pkg::MSS_SEQ_DONE); // RULE15
		n.out_term[1] = out_fn(s.mfo_fn[15:8], n.seq != mss_pkg::MSS_SEQ_IDLE
			&& n.seq != mss_pkg::MSS_SEQ_DONE, n.step_done,
			n.seq == mss_pkg::MSS_SEQ_DONE);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.seq <= mss_pkg::MSS_SEQ_IDLE;
			s.idx <= mss_pkg::MSS_IDX_NONE;
			s.deb_time <= `MSS_DEB_RST;
			s.gear <= `MSS_GEAR_RST;
			s.angle <= `MSS_ANGLE_RST;
			s.idx_dec <= `MSS_IDXDEC_RST;
			s.mode <= `MSS_MODE_RST;
		end else begin
			s <= n;
		end
	end

	assign reg_rdata = mem_q;
	assign freq_out = s.freq_out;
	assign dir_out = s.dir_out;
	assign decel_go = s.decel_go;
	assign out_term = s.out_term;
	assign irq = s.irq;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence seq_stop_armed;
		s.idx == mss_pkg::MSS_IDX_WAIT && stop_cmd && !(prox_lvl && !s.prox_q);
	endsequence

	chk_sel_master: assert property (s.seq == mss_pkg::MSS_SEQ_IDLE && // RULE1
		s.idx == mss_pkg::MSS_IDX_NONE && !stop_cmd && s.code_q == 4'h0
		|=> freq_out == $past(master_freq))
		else $error("master frequency not selected on code zero");
	chk_deb_range: assert property (s.deb_time >= 5'h01 && // RULE2
		s.deb_time <= 5'h14)
		else $error("debounce time out of range");
	chk_idx_range: assert property (s.gear >= 16'h0004 && // RULE4
		s.gear <= 16'h03E8 && s.angle <= 16'h0E10 && s.idx_dec <= 16'h2710)
		else $error("index setting out of range");
	chk_mode_range: assert property (s.mode <= 3'h4) // RULE10
		else $error("program mode out of range");
	chk_idx_hold: assert property (seq_stop_armed |=> $stable(freq_out) // RULE8
		&& !decel_go)
		else $error("speed not held while waiting for sensor");
	chk_idx_trig: assert property (seq_stop_armed ##1 (stop_cmd && // RULE9
		prox_lvl && !s.prox_q) |=> decel_go && s.idx == mss_pkg::MSS_IDX_DECEL)
		else $error("deceleration not started on sensor trigger");
	chk_step_dir: assert property (s.seq == mss_pkg::MSS_SEQ_LOAD && // RULE16
		mem_dur != 16'h0000 && run_lvl && s.mode != 3'h0
		|=> dir_out == $past(s.dir_word[s.step - 4'h1]))
		else $error("step direction not taken from direction word");
	chk_skip_zero: assert property (s.seq == mss_pkg::MSS_SEQ_LOAD && // RULE17
		mem_dur == 16'h0000 && s.step != 4'hF && run_lvl && s.mode != 3'h0
		|=> s.seq == mss_pkg::MSS_SEQ_LOAD && s.step == $past(s.step) + 4'h1)
		else $error("zero duration step not skipped");
	chk_step_pulse: assert property (s.step_done |-> // RULE19
		$past(s.seq) == mss_pkg::MSS_SEQ_RUN && $past(s.sec_cnt) == 16'h0001
		##1 !s.step_done)
		else $error("step flag not a single advance pulse");
	chk_once_stop: assert property (s.seq == mss_pkg::MSS_SEQ_DONE && // RULE12
		run_lvl && s.mode != 3'h0 |=> s.seq == mss_pkg::MSS_SEQ_DONE)
		else $error("one-cycle mode restarted without run toggle");
	chk_irq_level: assert property (irq == |(s.int_stat & s.int_mask))
		else $error("interrupt output disagrees with status");
endmodule

// ### multistep_speed_sequencer_tb.sv
`timescale 1ns/100ps
module multistep_speed_sequencer_tb;
	localparam logic [15:0] MASTER = 16'h1234;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [3:0] sel;
	logic [1:0] mfi_term;
	logic dir_cmd = 1'b0;
	logic stop_cmd = 1'b0;
	logic [15:0] freq_out;
	logic dir_out;
	logic decel_go;
	logic irq;
	logic [1:0] out_term;
	logic [5:0] cmd = 6'h00;
	logic [3:0] bounce = 4'h0;
	logic [7:0] pulse_cnt;
	logic [7:0] p0;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [5:0] ra[7] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h2A, 6'h3F};
	logic [15:0] rv[7] = '{16'h0001, 16'h00C8, 16'h0708, 16'h0000,
		16'h0000, 16'h0000, 16'h0000};
	logic [5:0] ca[8] = '{6'h21, 6'h21, 6'h20, 6'h20, 6'h22, 6'h23,
		6'h24, 6'h00};
	logic [15:0] cw[8] = '{16'h0002, 16'h07D0, 16'h0000, 16'h0019,
		16'hFFFF, 16'hFFFF, 16'h0007, 16'hFFFF};
	logic [15:0] cv[8] = '{16'h0004, 16'h03E8, 16'h0001, 16'h0014,
		16'h0E10, 16'h2710, 16'h0004, 16'h9C40};

	mss_top #(.DEB_TICK_CYC(4), .STEP_TICK_CYC(8)) uut (
		.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .speed_select_bit0(sel[0]),
		.speed_select_bit1(sel[1]), .speed_select_bit2(sel[2]),
		.speed_select_bit3(sel[3]), .mfi_term(mfi_term),
		.master_freq(MASTER), .dir_cmd(dir_cmd), .stop_cmd(stop_cmd),
		.freq_out(freq_out), .dir_out(dir_out), .decel_go(decel_go),
		.out_term(out_term), .irq(irq)
	);

	mss_field field (
		.sys_clk(sys_clk), .cmd(cmd), .bounce(bounce),
		.step_term(out_term[0]), .speed_select_bit0(sel[0]),
		.speed_select_bit1(sel[1]), .speed_select_bit2(sel[2]),
		.speed_select_bit3(sel[3]), .mfi_term(mfi_term),
		.pulse_cnt(pulse_cnt)
	);

	always #4 sys_clk = ~sys_clk;

	task automatic end_of_test();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask

	task automatic set_in(input logic [1:0] mfi, input logic [3:0] code);
		@(posedge sys_clk);
		cmd <= {mfi, code};
	endtask

	task automatic wait_freq(input logic [15:0] e, input int n);
		for (int i = 0; i < n && freq_out !== e; i++) tick(1);
		check(freq_out, e);
	endtask

	function automatic logic probe(input int s);
		return (s == 0) ? out_term[1] : decel_go;
	endfunction

	task automatic wait_sig(input int s, input int n);
		for (int i = 0; i < n && probe(s) !== 1'b1; i++) tick(1);
		check(probe(s), 16'h0001);
	endtask

	initial begin
		int i;
		int m;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		wr(6'h3F, 16'hA5A5);
		for (i = 0; i < 7; i++) rd(ra[i], rv[i]);
		for (i = 0; i < 8; i++) begin
			wr(ca[i], cw[i]);
			rd(ca[i], cv[i]);
		end
		wr(6'h20, 16'h0001);
		wr(6'h24, 16'h0000);
		for (i = 1; i < 16; i++) wr(6'(i - 1), 16'(i * 100));
		for (i = 0; i < 16; i++) begin
			set_in(2'b00, 4'(i));
			wait_freq((i == 0) ? MASTER : 16'(i * 100), 30);
		end
		// Chatter restarts the stable count, so the old code must persist
		wr(6'h20, 16'h0005);
		bounce <= 4'h8;
		set_in(2'b00, 4'h1);
		tick(20);
		check(freq_out, 16'h05DC);
		wait_freq(16'h0064, 60);
		bounce <= 4'h0;
		wr(6'h20, 16'h0001);
		wr(6'h10, 16'h0001);
		wr(6'h12, 16'h0003);
		wr(6'h25, 16'h0001);
		wr(6'h26, 16'h0F0E);
		wr(6'h27, 16'h0C0B);
		wr(6'h2A, 16'h0003);
		dir_cmd <= 1'b1;
		for (m = 1; m < 5; m++) begin
			set_in(2'b00, 4'h0);
			tick(20);
			wr(6'h24, 16'(m));
			p0 = pulse_cnt;
			set_in(2'b01, 4'h0);
			wait_freq(16'h0064, 40);
			if (m == 1) check(dir_out, 16'h0001);
			wait_freq(16'h012C, 30);
			if (m == 1) check(dir_out, 16'h0000);
			if (m == 2) begin
				set_in(2'b11, 4'h0);
				tick(60);
				check(freq_out, 16'h012C);
				set_in(2'b01, 4'h0);
			end
			if (m[0]) begin
				wait_sig(0, 60);
				check(pulse_cnt, {8'h00, p0 + 8'h02});
			end else begin
				wait_freq(16'h0064, 60);
			end
			if (m == 1) begin
				tick(2);
				check(irq, 16'h0001);
				rd(6'h29, 16'h0003);
				tick(2);
				check(irq, 16'h0000);
				tick(40);
				check(pulse_cnt, {8'h00, p0 + 8'h02});
				set_in(2'b00, 4'h0);
				tick(20);
				set_in(2'b01, 4'h0);
				wait_freq(16'h0064, 40);
			end
		end
		wr(6'h27, 16'h0A0B);
		tick(2);
		check(out_term[1], 16'h0001);
		set_in(2'b00, 4'h0);
		tick(20);
		check(out_term[1], 16'h0000);
		wr(6'h24, 16'h0000);
		set_in(2'b01, 4'h2);
		wait_freq(16'h00C8, 40);
		set_in(2'b00, 4'h1);
		wait_freq(16'h0064, 40);
		wr(6'h26, 16'h2200);
		wr(6'h2A, 16'h0004);
		rd(6'h29, 16'h0003);
		@(posedge sys_clk);
		stop_cmd <= 1'b1;
		tick(20);
		check(decel_go, 16'h0000);
		check(freq_out, 16'h0064);
		check(irq, 16'h0000);
		set_in(2'b10, 4'h1);
		wait_sig(1, 40);
		tick(2);
		check(irq, 16'h0001);
		@(posedge sys_clk);
		stop_cmd <= 1'b0;
		tick(3);
		check(decel_go, 16'h0000);
		set_in(2'b00, 4'h1);
		wr(6'h26, 16'h0000);
		@(posedge sys_clk);
		stop_cmd <= 1'b1;
		tick(3);
		check(decel_go, 16'h0001);
		end_of_test();
	end
endmodule
